// *** core/pier_gate.sv ***
/*
 * Per-source gating of request flags by enable bits, registered.
 * Assumes flags come from logic on the same clock.
 */
`timescale 1ns/10ps
module pier_gate #(
    parameter int unsigned WIDTH = 24
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Flags and enables
    input  wire logic [WIDTH-1:0] flag,
    input  wire logic [WIDTH-1:0] enable,
    // Gated requests
    output logic      [WIDTH-1:0] req_ff
);

    // One flop per source, request only while flag and enable both set
    for (genvar i = 0; i < WIDTH; i++) begin : g_src
        always_ff @(posedge clock) begin
            if (rst) begin
                req_ff[i] <= 1'b0;
            end else begin
                req_ff[i] <= flag[i] & enable[i];
            end
        end
    end

endmodule

// *** core/pier_sticky.sv ***
/*
 * Sticky event bits with write-one-to-clear; a set beats a clear.
 * Assumes set and clear are single-cycle strobes on the same clock.
 */
`timescale 1ns/10ps
module pier_sticky #(
    parameter int unsigned WIDTH = 24
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Set and clear strobes
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clr,
    // Held status
    output logic      [WIDTH-1:0] status_ff
);

    // Set wins so an event in the clearing cycle is kept
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (rst) begin
                status_ff[i] <= 1'b0;
            end else begin
                status_ff[i] <= set[i] | (status_ff[i] & ~clr[i]);
            end
        end
    end

endmodule

// *** core/pier_top.sv ***
/*
 * Peripheral interrupt enable registers with per-source request gating,
 * an Avalon-MM slave with waitrequest, and a masked sticky event interrupt.
 * Assumes source flags are synchronous to clock and reset is synchronous.
 */
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pier_top #(
    parameter int unsigned PINS = pier_pkg::PIER_PINS
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,

    // Avalon-MM slave
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,

    // Peripheral flag sources
    input  wire pier_pkg::pier_src_t   src_flag,

    // Toward the core
    output pier_pkg::pier_src_t        core_req,
    output logic                       irq
);

    // Variant masks, fixed at elaboration
    localparam logic [7:0] VAR_100 =
        (PINS >= 100) ? pier_pkg::PIER_PIN100 : 8'h00;
    localparam logic [7:0] VAR_80 =
        (PINS >= 80) ? pier_pkg::PIER_PIN80 : 8'h00;

    // Writable bits per register
    localparam logic [7:0] WMASK_ONE =
        pier_pkg::PIER_WR_ONE;
    localparam logic [7:0] WMASK_TWO =
        pier_pkg::PIER_WR_TWO;
    localparam logic [7:0] WMASK_THREE =
        pier_pkg::PIER_WR_THREE & (VAR_100 | 8'h0F);

    // Bits that gate a real source
    localparam logic [7:0] GMASK_TWO =
        pier_pkg::PIER_GATE_TWO;
    localparam logic [7:0] GMASK_THREE =
        8'h0F | VAR_100 | VAR_80;

    // Register state
    logic [7:0]  en_one_ff;
    logic [7:0]  en_two_ff;
    logic [7:0]  en_three_ff;
    logic [23:0] evt_mask_ff;
    logic [31:0] rdata_ff;
    logic        wait_ff;
    logic        irq_ff;

    // Next values
    logic [7:0]  nxt_en_one;
    logic [7:0]  nxt_en_two;
    logic [7:0]  nxt_en_three;
    logic [23:0] nxt_evt_mask;
    logic [31:0] nxt_rdata;
    logic        nxt_wait;
    logic        nxt_irq;

    // Bus decode
    wire         req_any;
    wire         acc_now;
    wire         wr_now;
    wire         sel_one;
    wire         sel_two;
    wire         sel_three;
    wire         sel_flags;
    wire         sel_status;
    wire         sel_mask;
    wire [31:0]  be_bits;

    // Gating and events
    pier_pkg::pier_src_t en_eff;
    pier_pkg::pier_src_t req_ff;
    logic [23:0]         req_prev_ff;
    wire  [23:0]         evt_set;
    wire  [23:0]         evt_clr;
    wire  [23:0]         evt_status;
    wire  [23:0]         evt_pend;

    // Byte-lane expansion of byteenable
    assign be_bits = {
        {8{avs_byteenable[3]}},
        {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}},
        {8{avs_byteenable[0]}}
    };

    // A request is held until waitrequest is seen low
    assign req_any = avs_read | avs_write;
    assign acc_now = req_any & ~wait_ff;
    assign wr_now  = avs_write & ~wait_ff;

    // Address decode; anything else reads zero, writes drop
    assign sel_one    = (avs_address == pier_pkg::PIER_OFF_EN_ONE);
    assign sel_two    = (avs_address == pier_pkg::PIER_OFF_EN_TWO);
    assign sel_three  = (avs_address == pier_pkg::PIER_OFF_EN_THREE);
    assign sel_flags  = (avs_address == pier_pkg::PIER_OFF_FLAGS);
    assign sel_status = (avs_address == pier_pkg::PIER_OFF_STATUS);
    assign sel_mask   = (avs_address == pier_pkg::PIER_OFF_MASK);

    // Enable one: only the low three bits store
    always_comb begin
        nxt_en_one = en_one_ff;
        if (wr_now && sel_one && avs_byteenable[0]) begin
            nxt_en_one = avs_writedata[7:0] & WMASK_ONE;
        end
    end

    // Enable two: bit 2 never stores, bit 4 stores but gates nothing
    always_comb begin
        nxt_en_two = en_two_ff;
        if (wr_now && sel_two && avs_byteenable[0]) begin
            nxt_en_two = avs_writedata[7:0] & WMASK_TWO;
        end
    end

    // Enable three: async two bits are read-only, variant bits 7:6 absent below 100 pins
    always_comb begin
        nxt_en_three = en_three_ff;
        if (wr_now && sel_three && avs_byteenable[0]) begin
            nxt_en_three = avs_writedata[7:0] & WMASK_THREE;
        end
    end

    // Event mask, byte lanes honoured
    always_comb begin
        nxt_evt_mask = evt_mask_ff;
        if (wr_now && sel_mask) begin
            nxt_evt_mask = (avs_writedata[23:0] & be_bits[23:0])
                         | (evt_mask_ff & ~be_bits[23:0]);
        end
    end

    // Write-one-to-clear strobe for the event status
    assign evt_clr = (wr_now && sel_status) ?
                     (avs_writedata[23:0] & be_bits[23:0]) : 24'h000000;

    // Read mux, sampled on the edge that drops waitrequest
    always_comb begin
        nxt_rdata = rdata_ff;
        if (req_any && wait_ff && avs_read) begin
            nxt_rdata = 32'h00000000;
            if (sel_one) begin
                nxt_rdata[7:0] = en_one_ff;
            end
            if (sel_two) begin
                nxt_rdata[7:0] = en_two_ff;
            end
            if (sel_three) begin
                nxt_rdata[7:0] = en_three_ff;
            end
            if (sel_flags) begin
                nxt_rdata[23:0] = src_flag;
            end
            if (sel_status) begin
                nxt_rdata[23:0] = evt_status;
            end
            if (sel_mask) begin
                nxt_rdata[23:0] = evt_mask_ff;
            end
        end
    end

    // One wait cycle per access, then back high until the next request
    assign nxt_wait = ~(req_any & wait_ff);

    // Storage of the enables and the event mask
    always_ff @(posedge clock) begin
        if (rst) begin
            en_one_ff   <= pier_pkg::PIER_EN_RESET;
            en_two_ff   <= pier_pkg::PIER_EN_RESET;
            en_three_ff <= pier_pkg::PIER_EN_RESET;
            evt_mask_ff <= pier_pkg::PIER_EVT_RESET;
        end else begin
            en_one_ff   <= nxt_en_one;
            en_two_ff   <= nxt_en_two;
            en_three_ff <= nxt_en_three;
            evt_mask_ff <= nxt_evt_mask;
        end
    end

    // Bus handshake flops; waitrequest idles high
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
            wait_ff  <= 1'b1;
        end else begin
            rdata_ff <= nxt_rdata;
            wait_ff  <= nxt_wait;
        end
    end

    // Effective enables: reserved and unimplemented bits never gate
    always_comb begin
        en_eff.one   = en_one_ff & WMASK_ONE;
        en_eff.two   = en_two_ff & GMASK_TWO;
        en_eff.three = en_three_ff & GMASK_THREE;
    end

    // Per-source gate; enable low blocks, enable high passes
    pier_gate #(
        .WIDTH (pier_pkg::PIER_SRC_W)
    ) u_gate (
        .clock  (clock),
        .rst    (rst),
        .flag   (src_flag),
        .enable (en_eff),
        .req_ff (req_ff)
    );

    // Previous requests for rise detection
    always_ff @(posedge clock) begin
        if (rst) begin
            req_prev_ff <= pier_pkg::PIER_EVT_RESET;
        end else begin
            req_prev_ff <= req_ff;
        end
    end

    // An event is a gated request that has just risen
    assign evt_set = req_ff & ~req_prev_ff;

    // Sticky event status, set wins over a same-cycle clear
    pier_sticky #(
        .WIDTH (pier_pkg::PIER_SRC_W)
    ) u_sticky (
        .clock     (clock),
        .rst       (rst),
        .set       (evt_set),
        .clr       (evt_clr),
        .status_ff (evt_status)
    );

    // Level interrupt while any unmasked event is pending
    assign evt_pend = evt_status & evt_mask_ff;
    assign nxt_irq  = |evt_pend;

    // Interrupt output flop; costs one cycle but keeps the pin glitch free
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // Outputs straight from flops
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign core_req        = req_ff;
    assign irq             = irq_ff;

endmodule

// *** include/pier_pkg.sv ***
/*
 * Shared constants and types for the peripheral interrupt enable block.
 * Assumes one 100 MHz clock and a word-aligned Avalon-MM register bus.
 */
package pier_pkg;

    // Register byte offsets
    localparam logic [4:0] PIER_OFF_EN_ONE   = 5'h00;
    localparam logic [4:0] PIER_OFF_EN_TWO   = 5'h04;
    localparam logic [4:0] PIER_OFF_EN_THREE = 5'h08;
    localparam logic [4:0] PIER_OFF_FLAGS    = 5'h0C;
    localparam logic [4:0] PIER_OFF_STATUS   = 5'h10;
    localparam logic [4:0] PIER_OFF_MASK     = 5'h14;

    // Widths
    localparam int unsigned PIER_ADDR_W = 5;
    localparam int unsigned PIER_DATA_W = 32;
    localparam int unsigned PIER_SRC_W  = 24;
    localparam int unsigned PIER_PINS   = 100;

    // Values after reset
    localparam logic [7:0]  PIER_EN_RESET  = 8'h00;
    localparam logic [23:0] PIER_EVT_RESET = 24'h000000;

    // Enable one: bit positions
    localparam int unsigned PIER_B1_CAPCOMP_ONE = 2;
    localparam int unsigned PIER_B1_TIMER_TWO   = 1;
    localparam int unsigned PIER_B1_TIMER_ONE   = 0;

    // Enable two: bit positions
    localparam int unsigned PIER_B2_OSC_FAIL    = 7;
    localparam int unsigned PIER_B2_COMPARATOR  = 6;
    localparam int unsigned PIER_B2_ETHERNET    = 5;
    localparam int unsigned PIER_B2_RESERVED    = 4;
    localparam int unsigned PIER_B2_COLL_ONE    = 3;
    localparam int unsigned PIER_B2_UNIMPL      = 2;
    localparam int unsigned PIER_B2_TIMER_THREE = 1;
    localparam int unsigned PIER_B2_CAPCOMP_TWO = 0;

    // Enable three: bit positions
    localparam int unsigned PIER_B3_SERIAL_TWO  = 7;
    localparam int unsigned PIER_B3_COLL_TWO    = 6;
    localparam int unsigned PIER_B3_ASYNC_RX    = 5;
    localparam int unsigned PIER_B3_ASYNC_TX    = 4;
    localparam int unsigned PIER_B3_TIMER_FOUR  = 3;
    localparam int unsigned PIER_B3_CAPCOMP_5   = 2;
    localparam int unsigned PIER_B3_CAPCOMP_4   = 1;
    localparam int unsigned PIER_B3_CAPCOMP_3   = 0;

    // Storage and gating masks
    localparam logic [7:0] PIER_WR_ONE   = 8'h07;
    localparam logic [7:0] PIER_WR_TWO   = 8'hFB;
    localparam logic [7:0] PIER_GATE_TWO = 8'hEB;
    localparam logic [7:0] PIER_WR_THREE = 8'hCF;
    localparam logic [7:0] PIER_PIN100   = 8'hC0;
    localparam logic [7:0] PIER_PIN80    = 8'h30;

    // One byte per enable register, same layout for flags and events
    typedef struct packed {
        logic [7:0] three;
        logic [7:0] two;
        logic [7:0] one;
    } pier_src_t;

endpackage

// *** tb/pier_assertions.sv ***
/*
 * Port-level checks of the enable block.
 * Assumes it is bound into every pier_top instance.
 */
`timescale 1ns/10ps
module pier_checker #(
    parameter int unsigned PINS = 100
) (
    // Clock and reset
    input wire logic                clock,
    input wire logic                rst,
    // Register bus
    input wire logic [4:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic [3:0]          avs_byteenable,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    // Flags and requests
    input wire pier_pkg::pier_src_t src_flag,
    input wire pier_pkg::pier_src_t core_req,
    input wire logic                irq
);
    wire logic rd_ok;
    wire logic wr_ok;

    // Accesses that complete on this edge; writes only with byte lane 0 enabled
    assign rd_ok = avs_read && !avs_waitrequest;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_req_needs_flag:
        assert property ((core_req & ~$past(src_flag)) == 24'h000000)
        else $error("Request without a flag");
    a_wr_one_blocks:
        assert property (wr_ok && avs_address == 5'h00 && !avs_writedata[0]
            |-> ##2 !core_req.one[0]) else $error("Timer one not blocked");
    a_wr_two_blocks:
        assert property (wr_ok && avs_address == 5'h04 && avs_writedata[7:0] == 8'h00
            |-> ##2 core_req.two == 8'h00) else $error("Enable two not blocking");
    a_bit_two_dead:
        assert property (core_req.two[2] == 1'h0) else $error("Bit two passed");
    a_async_blocked:
        assert property (core_req.three[5:4] == 2'h0
            && (PINS >= 100 || core_req.three[7:6] == 2'h0)) else $error("Bad source");
    a_reset_clears:
        assert property ($past(rst) |-> core_req == 24'h000000 && !irq)
        else $error("Request after reset");
    a_rd_two_bits:
        assert property (rd_ok && avs_address == 5'h04
            |-> avs_readdata[2] == 1'h0) else $error("Bit two read back");
    a_rd_three_async:
        assert property (rd_ok && avs_address == 5'h08
            |-> avs_readdata[5:4] == 2'h0) else $error("Async bits read back");
endmodule

bind pier_top pier_checker #(.PINS(PINS)) chk_u (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_flag(src_flag),
    .core_req(core_req), .irq(irq)
);

// *** tb/pier_flag_src.sv ***
/*
 * Far-side model: peripheral flag sources feeding the gate.
 * Assumes the bench changes the pattern just after a clock edge.
 */
`timescale 1ns/10ps
module pier_flag_src (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Pattern the peripherals raise
    input  wire pier_pkg::pier_src_t pattern,
    // Flags toward the gate
    output pier_pkg::pier_src_t      src_flag
);
    pier_pkg::pier_src_t flag_ff;

    // Registered like a peripheral's own flag flop, so flags move on edges only
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= pattern;
        end
    end
    assign src_flag = flag_ff;
endmodule

// *** tb/tb_top.sv ***
/*
 * Self-checking bench: register rows, gating, event interrupt, reset.
 * Assumes one 100 MHz clock and the Avalon-MM timing of the block.
 */
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [7:0]  e1;
        logic [7:0]  e2;
        logic [7:0]  e3;
        logic [23:0] flag;
        logic [23:0] exp;
    } pier_row_t;

    logic                clock = 1'h0;
    logic                rst   = 1'h1;
    logic [4:0]          addr  = 5'h00;
    logic                rd_en = 1'h0;
    logic                wr_en = 1'h0;
    logic [31:0]         wdata = 32'h00000000;
    logic [3:0]          be    = 4'hF;
    logic [31:0]         rdata;
    logic [31:0]         rdata_s;
    logic                wreq;
    logic                irq;
    pier_pkg::pier_src_t pat   = '0;
    pier_pkg::pier_src_t src_flag;
    pier_pkg::pier_src_t core_req;
    pier_pkg::pier_src_t req_s;
    logic [31:0]         rd;
    logic [31:0]         rd_s;
    int                  error_cnt = 0;
    int                  samples_checked = 0;
    // Bit 4 of enable two is always written as zero
    pier_row_t           rows [4] = '{
        '{8'h07, 8'hEF, 8'hFF, 24'hFFFFFF, 24'hCFEB07},
        '{8'h05, 8'hA2, 8'h8A, 24'hFFFFFF, 24'h8AA205},
        '{8'h02, 8'h41, 8'h4C, 24'h5555AA, 24'h444102},
        '{8'h00, 8'h00, 8'h00, 24'hFFFFFF, 24'h000000}};

    always #5 clock = ~clock;

    // Full build, and a 64-pin build that must lose the upper enable-three bits
    pier_top #(.PINS(100)) dut_u (.clock(clock), .rst(rst), .avs_address(addr),
        .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .src_flag(src_flag), .core_req(core_req), .irq(irq));
    pier_top #(.PINS(64)) dut_u64 (.clock(clock), .rst(rst), .avs_address(addr),
        .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata_s), .avs_waitrequest(),
        .src_flag(src_flag), .core_req(req_s), .irq());
    pier_flag_src src_u (.clock(clock), .rst(rst), .pattern(pat), .src_flag(src_flag));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is sampled low, released at that edge, then one more edge before return
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr  <= a;
        wdata <= d;
        wr_en <= wr;
        rd_en <= !wr;
        @(posedge clock);
        while (wreq !== 1'h0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) error_cnt++;
        rd = rdata;
        rd_s = rdata_s;
        wr_en <= 1'h0;
        rd_en <= 1'h0;
        @(posedge clock);
    endtask

    // Every mapped place plus one unmapped address must read zero
    task automatic zero_regs;
        for (int a = 0; a <= 24; a += 4) begin
            bus(1'h0, 5'(a), 32'h0);
            check(rd, 32'h0);
        end
    endtask

    task automatic wrap_up;
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        zero_regs();
        foreach (rows[i]) begin
            pat <= rows[i].flag;
            bus(1'h1, 5'h00, {24'h0, rows[i].e1});
            bus(1'h1, 5'h04, {24'h0, rows[i].e2});
            bus(1'h1, 5'h08, {24'h0, rows[i].e3});
            bus(1'h0, 5'h00, 32'h0);
            check(rd, {24'h0, rows[i].e1 & 8'h07});
            bus(1'h0, 5'h04, 32'h0);
            check(rd, {24'h0, rows[i].e2 & 8'hFB});
            bus(1'h0, 5'h08, 32'h0);
            check(rd, {24'h0, rows[i].e3 & 8'hCF});
            check(rd_s, {24'h0, rows[i].e3 & 8'h0F});
            check({8'h00, core_req}, {8'h00, rows[i].exp});
            check({8'h00, req_s}, {8'h00, rows[i].exp & 24'h0FFFFF});
        end
        // Unmapped write must leave nothing behind
        bus(1'h1, 5'h18, 32'hFFFFFFFF);
        bus(1'h0, 5'h18, 32'h0);
        check(rd, 32'h0);
        // Write with lane 0 off must not reach enable one
        be <= 4'hE;
        bus(1'h1, 5'h00, 32'h00000007);
        be <= 4'hF;
        bus(1'h0, 5'h00, 32'h0);
        check(rd, 32'h0);
        // Event from timer one: masked first, then raised, then cleared
        pat <= 24'h000001;
        bus(1'h1, 5'h10, 32'h00FFFFFF);
        bus(1'h1, 5'h00, 32'h00000001);
        repeat (3) @(posedge clock);
        bus(1'h0, 5'h10, 32'h0);
        check(rd, 32'h00000001);
        check({31'h0, irq}, 32'h0);
        bus(1'h0, 5'h0C, 32'h0);
        check(rd, 32'h00000001);
        bus(1'h1, 5'h14, 32'h00000001);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        bus(1'h1, 5'h10, 32'h00000001);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        // Load enables two and three so the reset below has bits to clear
        bus(1'h1, 5'h04, 32'h000000EB);
        bus(1'h1, 5'h08, 32'h000000CF);
        // Second reset in mid-run with a flag still pending
        rst <= 1'h1;
        repeat (2) @(posedge clock);
        pat <= '0;
        rst <= 1'h0;
        zero_regs();
        check({8'h00, core_req}, 32'h0);
        wrap_up();
    end
endmodule
